// File: core/ussu_core.v
`timescale 1ns/1ps
`include "ussu_consts.vh"

// Contract
// R1: Three-wire mode works as serial mode 0/1 unit, no select pin.
// R2: Every shift clock also advances the 4-bit counter.
// R3: Edge select 0 samples on rising edges, shifts output on falling.
// R4: Edge select 1 samples on falling edges, shifts output on rising.
// R5: Master clock made by port toggle or clock toggle strobe.
// R6: Both sides load data and enable drivers half a clock before sampling.
// R7: External clock counts both edges; sixteen edges overflow a byte.
// R8: Enabled overflow flag can wake the processor from idle.
// R9: Two-wire mode has no slew limiting nor input filtering.
// R10: Two-wire master clocks by software; only slave holds clock line.
// R11: Two-wire master checks clock line really rose after release.
// R12: Master starts by pulling data low while clock high.
// R13: Start sets flag, then clock held low after next falling edge.
// R14: Two-wire slave samples data on each rising clock edge.
// R15: Counter overflow after eight bits holds clock low until released.
// R16: Acknowledge bit uses counter preload of 14 before clock release.
// R17: Unaddressed slave releases clock and waits for next start.
// R18: Slave unable to take data withholds the acknowledge.
// R19: Data line delayed 50 to 300 ns against clock for start detect.
// R20: Start detection works without the system clock for power-down wake.
// R21: Stand-alone counter increments on both external clock edges.
// R22: Counter chains with timer overflow to form 12-bit counter.
// R23: Overflow flag sets when counter wraps from 15 to 0.
// R24: Flags clear only by writing one; clearing releases their hold.
// R25: Shift clock colliding with register write keeps written value.
// R26: Shift toward MSB, bit 7 out, sampled input into bit 0.
module ussu_core #(
	parameter SR_W       = `USSU_SR_W,
	parameter CNT_W      = `USSU_CNT_W,
	parameter FIFO_DEPTH = `USSU_FIFO_DEPTH,
	parameter FIFO_AW    = `USSU_FIFO_AW
) (
	// Clock and reset
	input  wire             sys_clk_i,
	input  wire             rst_b_i,
	// Serial pins
	input  wire             serial_clock_pin_i,
	output wire             serial_clock_pin_o,
	output wire             serial_clock_pin_oe_o,
	input  wire             serial_in_pin_i,
	output wire             data_pin_o,
	output wire             data_pin_oe_o,
	output wire             serial_out_pin_o,
	output wire             serial_out_pin_oe_o,
	// Configuration
	input  wire [1:0]       wire_mode_i,
	input  wire             external_clock_select_i,
	input  wire             edge_select_i,
	input  wire             clock_dir_i,
	input  wire             data_dir_i,
	input  wire             start_irq_en_i,
	input  wire             ovf_irq_en_i,
	// Strobes and clock sources
	input  wire             soft_clock_strobe_i,
	input  wire             clock_toggle_strobe_i,
	input  wire             timer_overflow_i,
	input  wire             clock_port_wr_i,
	input  wire             clock_port_wdata_i,
	// Shift register and counter access
	input  wire             shift_register_wr_i,
	input  wire [SR_W-1:0]  shift_register_wdata_i,
	input  wire             count_wr_i,
	input  wire [CNT_W-1:0] count_wdata_i,
	output wire [SR_W-1:0]  shift_register_o,
	output wire [CNT_W-1:0] count_o,
	// Flags
	input  wire             start_clr_i,
	input  wire             ovf_clr_i,
	input  wire             stop_clr_i,
	output wire             start_detect_flag_o,
	output wire             count_overflow_flag_o,
	output wire             stop_flag_o,
	output wire             collision_o,
	output wire             count_wrap_o,
	// Wake and interrupt requests
	output wire             start_irq_o,
	output wire             idle_wake_o,
	output wire             powerdown_wake_o,
	// Received byte stream
	output wire             rx_valid_o,
	input  wire             rx_ready_i,
	output wire [SR_W-1:0]  rx_data_o
);

	// ==========================================================
	// Pin synchronisers
	wire [1:0] pin_raw = {serial_clock_pin_i, serial_in_pin_i};
	reg  [1:0] pin_s1_q;
	reg  [1:0] pin_s2_q;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			always @(posedge sys_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					pin_s1_q[gi] <= 1'b1;
					pin_s2_q[gi] <= 1'b1;
				end else begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
				end
			end
		end
	endgenerate

	wire scl_s = pin_s2_q[1];
	wire din_s = pin_s2_q[0];

	// ==========================================================
	// Edge detection and delayed data line
	localparam DLY = `USSU_SDA_DLY_CYC;
	reg           scl_prev_q;
	reg [DLY-1:0] sda_dly_q;
	reg           sda_dly_prev_q;

	wire scl_rise = scl_s & ~scl_prev_q;
	wire scl_fall = ~scl_s & scl_prev_q;
	wire sda_dly  = sda_dly_q[DLY-1];

	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_prev_q     <= 1'b1;
			sda_dly_q      <= {DLY{1'b1}};
			sda_dly_prev_q <= 1'b1;
		end else begin
			scl_prev_q     <= scl_s;
			sda_dly_q      <= {sda_dly_q[DLY-2:0], din_s}; // [R19]
			sda_dly_prev_q <= sda_dly;
		end
	end

	// ==========================================================
	// Mode decode
	function is_two_wire;
		input [1:0] wm;
		begin
			is_two_wire = (wm == `USSU_WM_TWO) || (wm == `USSU_WM_TWO_HOLD);
		end
	endfunction

	wire two_wire   = is_two_wire(wire_mode_i);
	wire three_wire = (wire_mode_i == `USSU_WM_THREE); // [R1]
	wire ovf_hold_m = (wire_mode_i == `USSU_WM_TWO_HOLD);

	// ==========================================================
	// Shift clock selection
	// Sample edge rises with edge select 0, falls with 1
	wire ext_sample = edge_select_i ? scl_fall : scl_rise; // [R3] [R4] [R14]
	wire ext_shift  = edge_select_i ? scl_rise : scl_fall; // [R3] [R4] [R10]
	wire int_tick   = edge_select_i ? timer_overflow_i : soft_clock_strobe_i; // [R22]

	wire sample_tick = external_clock_select_i ? ext_sample : int_tick;
	// Both external edges count
	wire cnt_tick    = external_clock_select_i ? (scl_rise | scl_fall) : int_tick; // [R2] [R7] [R21]

	// ==========================================================
	// Shift register, counter and output latch
	reg  [SR_W-1:0]  sr_q;
	reg  [SR_W-1:0]  sr_d;
	reg  [CNT_W-1:0] cnt_q;
	reg  [CNT_W-1:0] cnt_d;
	reg              latch_open_q;
	reg              latch_open_d;
	reg              dout_q;
	reg              dout_d;

	wire cnt_wrap = cnt_tick & ~count_wr_i & (cnt_q == `USSU_CNT_MAX); // [R23]

	always @* begin
		sr_d = sr_q;
		if (shift_register_wr_i) begin
			sr_d = shift_register_wdata_i; // [R25]
		end else if (sample_tick) begin
			sr_d = {sr_q[SR_W-2:0], din_s}; // [R26]
		end
	end

	always @* begin
		cnt_d = cnt_q;
		if (count_wr_i) begin
			cnt_d = count_wdata_i;
		end else if (cnt_tick) begin
			cnt_d = cnt_q + 1'b1; // [R2]
		end
	end

	// Latch closes at the sample edge, opens at the shift edge
	always @* begin
		latch_open_d = latch_open_q;
		if (ext_sample) begin
			latch_open_d = 1'b0;
		end else if (ext_shift) begin
			latch_open_d = 1'b1;
		end
		dout_d = dout_q;
		if (~external_clock_select_i | latch_open_d) begin
			dout_d = sr_d[`USSU_SR_MSB]; // [R3] [R4] [R6]
		end
	end

	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sr_q         <= `USSU_SR_RST;
			cnt_q        <= `USSU_CNT_RST;
			latch_open_q <= 1'b1;
			dout_q       <= 1'b0;
		end else begin
			sr_q         <= sr_d;
			cnt_q        <= cnt_d;
			latch_open_q <= latch_open_d;
			dout_q       <= dout_d;
		end
	end

	// ==========================================================
	// Start, stop and overflow flags
	reg start_flag_q;
	reg ovf_flag_q;
	reg stop_flag_q;
	reg start_hold_q;
	reg ack_phase_q;

	// Clock high while delayed data falls
	wire start_det = two_wire & scl_s & ~sda_dly & sda_dly_prev_q; // [R12] [R19]
	wire stop_det  = two_wire & scl_s & sda_dly & ~sda_dly_prev_q;

	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			start_flag_q <= 1'b0;
			ovf_flag_q   <= 1'b0;
			stop_flag_q  <= 1'b0;
			start_hold_q <= 1'b0;
			ack_phase_q  <= 1'b0;
		end else begin
			// Set wins over clear
			start_flag_q <= start_det | (start_flag_q & ~start_clr_i); // [R13] [R24]
			ovf_flag_q   <= cnt_wrap | (ovf_flag_q & ~ovf_clr_i); // [R23] [R24]
			stop_flag_q  <= stop_det | (stop_flag_q & ~stop_clr_i);
			if (start_det | (start_clr_i & ~start_flag_q) | ~two_wire) begin
				start_hold_q <= 1'b0;
			end else if (start_clr_i) begin
				start_hold_q <= 1'b0; // [R17] [R24]
			end else if (start_flag_q & scl_fall) begin
				start_hold_q <= 1'b1; // [R13]
			end
			if (cnt_wrap) begin
				ack_phase_q <= 1'b0;
			end else if (two_wire & count_wr_i & (count_wdata_i == `USSU_CNT_ACK)) begin
				ack_phase_q <= 1'b1; // [R16]
			end
		end
	end

	// ==========================================================
	// Received byte capture into buffer
	reg             pend_q;
	reg [SR_W-1:0]  pend_data_q;
	wire            fifo_in_ready;

	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend_q      <= 1'b0;
			pend_data_q <= `USSU_SR_RST;
		end else begin
			if (cnt_wrap & ~ack_phase_q & (three_wire | two_wire)) begin
				pend_q      <= 1'b1;
				pend_data_q <= sr_d;
			end else if (fifo_in_ready) begin
				pend_q <= 1'b0;
			end
		end
	end

	ussu_fifo #(
		.WIDTH (SR_W),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk_i       (sys_clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (pend_q),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (pend_data_q),
		.out_valid_o (rx_valid_o),
		.out_ready_i (rx_ready_i),
		.out_data_o  (rx_data_o)
	);

	// ==========================================================
	// Clock port and line drive
	reg clk_port_q;

	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			clk_port_q <= 1'b0;
		end else if (clock_port_wr_i) begin
			clk_port_q <= clock_port_wdata_i; // [R5]
		end else if (clock_toggle_strobe_i) begin
			clk_port_q <= ~clk_port_q; // [R5]
		end
	end

	// Slave-side holds; a stalled buffer also stretches the clock
	wire ovf_hold = ovf_hold_m & ovf_flag_q; // [R15] [R24]
	wire buf_hold = two_wire & pend_q & ~fifo_in_ready;
	wire scl_hold = start_hold_q | ovf_hold | buf_hold; // [R10] [R11]

	// Raw output levels, no edge shaping on either line
	assign serial_clock_pin_o    = two_wire ? 1'b0 : clk_port_q; // [R9]
	assign serial_clock_pin_oe_o = two_wire ? ((clock_dir_i & ~clk_port_q) | scl_hold) : clock_dir_i;

	// No acknowledge when the buffer cannot take another byte
	wire ack_block  = ack_phase_q & (pend_q | ~fifo_in_ready); // [R18]
	wire sda_low    = data_dir_i & ~dout_q & ~ack_block; // [R16]

	assign data_pin_o          = 1'b0;
	assign data_pin_oe_o       = two_wire & sda_low; // [R9]
	assign serial_out_pin_o    = dout_q;
	assign serial_out_pin_oe_o = three_wire & data_dir_i; // [R1] [R6]

	// ==========================================================
	// Status and wake outputs
	assign shift_register_o      = sr_q;
	assign count_o               = cnt_q;
	assign start_detect_flag_o   = start_flag_q;
	assign count_overflow_flag_o = ovf_flag_q;
	assign stop_flag_o           = stop_flag_q;
	assign collision_o           = two_wire & (dout_q != din_s);
	assign count_wrap_o          = cnt_wrap; // [R22]
	assign start_irq_o           = start_irq_en_i & start_flag_q;
	assign idle_wake_o           = ovf_irq_en_i & ovf_flag_q; // [R8]

	// Clockless path: pins alone request wake from power-down
	assign powerdown_wake_o = two_wire & start_irq_en_i & (serial_clock_pin_i & ~serial_in_pin_i); // [R20]

endmodule // ussu_core

// File: shared/ussu_consts.vh
`ifndef USSU_CONSTS_VH
`define USSU_CONSTS_VH

// ==========================================================
// Wire modes
`define USSU_WM_OFF         2'h0
`define USSU_WM_THREE       2'h1
`define USSU_WM_TWO         2'h2
`define USSU_WM_TWO_HOLD    2'h3

// ==========================================================
// Counter and shift register
`define USSU_CNT_W          4
`define USSU_CNT_RST        4'h0
`define USSU_CNT_MAX        4'hf
`define USSU_CNT_ACK        4'he
`define USSU_SR_W           8
`define USSU_SR_RST         8'h00
`define USSU_SR_MSB         7

// ==========================================================
// Start detector data delay
`define USSU_CLK_PERIOD_NS  8
`define USSU_SDA_DLY_MIN_NS 50
`define USSU_SDA_DLY_MAX_NS 300
`define USSU_SDA_DLY_CYC    ((`USSU_SDA_DLY_MIN_NS + `USSU_CLK_PERIOD_NS - 1) / `USSU_CLK_PERIOD_NS)

// ==========================================================
// Receive buffer
`define USSU_FIFO_DEPTH     16
`define USSU_FIFO_AW        4

`endif

// File: core/ussu_fifo.v
`timescale 1ns/1ps

// ==========================================================
// Synchronous FIFO with valid/ready on both sides
module ussu_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset
	input  wire             clk_i,
	input  wire             rst_b_i,
	// Fill side
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	// Drain side
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output reg  [WIDTH-1:0] out_data_o
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_q;
	reg [AW-1:0]    rd_ptr_q;
	reg [AW:0]      fill_q;

	wire push = in_valid_i & in_ready_o;
	wire pop  = out_valid_o & out_ready_i;

	assign in_ready_o  = (fill_q != DEPTH[AW:0]);
	assign out_valid_o = (fill_q != {(AW+1){1'b0}});

	always @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data_i;
		end
	end

	always @* begin
		out_data_o = mem[rd_ptr_q];
	end

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			fill_q   <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
			end
			if (push & ~pop) begin
				fill_q <= fill_q + 1'b1;
			end else if (pop & ~push) begin
				fill_q <= fill_q - 1'b1;
			end
		end
	end

endmodule // ussu_fifo

// File: test/ussu_checker.sv
`timescale 1ns/1ps

// ==========================================================
// Port-level checks on the shift unit
module ussu_checker (
	// Clock and reset
	input wire       sys_clk_i,
	input wire       rst_b_i,
	// Watched ports
	input wire [1:0] wire_mode_i,
	input wire       external_clock_select_i,
	input wire       edge_select_i,
	input wire       data_dir_i,
	input wire       start_irq_en_i,
	input wire       ovf_irq_en_i,
	input wire       soft_clock_strobe_i,
	input wire       shift_register_wr_i,
	input wire [7:0] shift_register_wdata_i,
	input wire       count_wr_i,
	input wire [3:0] count_wdata_i,
	input wire       ovf_clr_i,
	input wire       serial_clock_pin_i,
	input wire       serial_in_pin_i,
	input wire [7:0] shift_register_o,
	input wire [3:0] count_o,
	input wire       count_overflow_flag_o,
	input wire       start_detect_flag_o,
	input wire       count_wrap_o,
	input wire       serial_out_pin_oe_o,
	input wire       start_irq_o,
	input wire       idle_wake_o,
	input wire       powerdown_wake_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	wire soft_tick = soft_clock_strobe_i & ~external_clock_select_i & ~edge_select_i & ~count_wr_i;

	a_tick_counts: assert property (soft_tick |=> count_o == $past(count_o) + 4'h1)
		else $error("soft tick did not advance the counter");
	a_tick_shifts: assert property (soft_tick && !shift_register_wr_i |=>
		shift_register_o[7:1] == $past(shift_register_o[6:0]))
		else $error("soft tick did not shift toward the top bit");
	a_write_wins: assert property (shift_register_wr_i |=> shift_register_o == $past(shift_register_wdata_i))
		else $error("written shift value not kept");
	a_count_load: assert property (count_wr_i |=> count_o == $past(count_wdata_i))
		else $error("counter load not kept");
	a_wrap_flag: assert property (count_wrap_o && !count_wr_i |=> count_overflow_flag_o && count_o == 4'h0)
		else $error("wrap did not set the overflow flag");
	a_flag_clear: assert property (ovf_clr_i && !count_wrap_o |=> !count_overflow_flag_o)
		else $error("overflow flag not cleared by one");
	a_flag_sticky: assert property (count_overflow_flag_o && !ovf_clr_i |=> count_overflow_flag_o)
		else $error("overflow flag dropped on its own");
	a_idle_wake: assert property (count_overflow_flag_o && ovf_irq_en_i |-> idle_wake_o)
		else $error("overflow did not request idle wake");
	a_start_irq: assert property (start_detect_flag_o && start_irq_en_i |-> start_irq_o)
		else $error("start flag did not raise its request");
	a_pd_wake: assert property (wire_mode_i[1] && start_irq_en_i && serial_clock_pin_i && !serial_in_pin_i
		|-> powerdown_wake_o)
		else $error("start level did not request power-down wake");
	a_out_enable: assert property (wire_mode_i == 2'h1 |-> serial_out_pin_oe_o == data_dir_i)
		else $error("three-wire output enable wrong");
endmodule // ussu_checker

bind ussu_core ussu_checker u_chk (
	.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wire_mode_i(wire_mode_i),
	.external_clock_select_i(external_clock_select_i), .edge_select_i(edge_select_i), .data_dir_i(data_dir_i),
	.start_irq_en_i(start_irq_en_i), .ovf_irq_en_i(ovf_irq_en_i), .soft_clock_strobe_i(soft_clock_strobe_i),
	.shift_register_wr_i(shift_register_wr_i), .shift_register_wdata_i(shift_register_wdata_i),
	.count_wr_i(count_wr_i), .count_wdata_i(count_wdata_i), .ovf_clr_i(ovf_clr_i),
	.serial_clock_pin_i(serial_clock_pin_i), .serial_in_pin_i(serial_in_pin_i),
	.shift_register_o(shift_register_o), .count_o(count_o), .count_overflow_flag_o(count_overflow_flag_o),
	.start_detect_flag_o(start_detect_flag_o), .count_wrap_o(count_wrap_o),
	.serial_out_pin_oe_o(serial_out_pin_oe_o), .start_irq_o(start_irq_o), .idle_wake_o(idle_wake_o),
	.powerdown_wake_o(powerdown_wake_o)
);

// File: test/ussu_partner.sv
`timescale 1ns/1ps

// ==========================================================
// Far-side serial master, clock mode 0 or 1
module ussu_partner #(
	parameter HALF_NS = 80
) (
	// Control
	input  wire       go_i,
	input  wire       mode1_i,
	input  wire [7:0] tx_i,
	// Serial lines
	input  wire       miso_i,
	output reg        sck_o,
	output reg        mosi_o,
	// Result
	output reg  [7:0] rx_o,
	output reg        busy_o
);
	integer i;

	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		rx_o = 8'h00;
		busy_o = 1'b0;
	end

	always @(posedge go_i) begin
		busy_o = 1'b1;
		#3;
		for (i = 7; i >= 0; i = i - 1) begin
			if (!mode1_i)
				mosi_o = tx_i[i]; // Half a cycle ahead of sampling
			#(HALF_NS) sck_o = 1'b1;
			if (mode1_i)
				mosi_o = tx_i[i];
			else
				rx_o = {rx_o[6:0], miso_i};
			#(HALF_NS) sck_o = 1'b0; // Clock idles low outside frames
			if (mode1_i)
				rx_o = {rx_o[6:0], miso_i};
		end
		#(HALF_NS) mosi_o = ~mosi_o; // Released line loses the last bit
		busy_o = 1'b0;
	end
endmodule // ussu_partner

// File: test/tb_ussu_core.sv
`timescale 1ns/1ps

module tb_ussu_core;
	reg        sys_clk, rst_b, ext_sel, edge_sel, clk_dir, data_dir, soft_stb, tgl_stb, tmr_ovf, irq_en, cp_wr, cp_wd;
	reg        sr_wr, cnt_wr, start_clr, ovf_clr, rx_ready, tb_scl, tb_sda, loop, p_go, p_mode1;
	reg  [1:0] wm;
	reg  [7:0] sr_wd, p_tx, m;
	reg  [3:0] cnt_wd;
	wire       scl_o, scl_oe, sda_o, sda_oe, so, so_oe, p_sck, p_mosi, p_busy;
	wire       st_f, ovf_f, wrap, s_irq, pd_wake, rx_valid, idle_w;
	wire [7:0] sr, rx_data, p_rx;
	wire [3:0] cnt;
	wire       scl_w = (scl_oe ? scl_o : 1'b1) & (p_busy ? p_sck : tb_scl);
	wire       sda_w = (sda_oe ? sda_o : 1'b1) & (p_busy ? p_mosi : (loop ? so : tb_sda));
	integer    error_cnt = 0, n_checks = 0, i, k;
	reg  [7:0] exp_q[$];

	ussu_core #(.FIFO_DEPTH(4), .FIFO_AW(2)) DUT (
		.sys_clk_i(sys_clk), .rst_b_i(rst_b), .serial_clock_pin_i(scl_w), .serial_clock_pin_o(scl_o),
		.serial_clock_pin_oe_o(scl_oe), .serial_in_pin_i(sda_w), .data_pin_o(sda_o), .data_pin_oe_o(sda_oe),
		.serial_out_pin_o(so), .serial_out_pin_oe_o(so_oe), .wire_mode_i(wm), .external_clock_select_i(ext_sel),
		.edge_select_i(edge_sel), .clock_dir_i(clk_dir), .data_dir_i(data_dir), .start_irq_en_i(irq_en),
		.ovf_irq_en_i(irq_en), .soft_clock_strobe_i(soft_stb), .clock_toggle_strobe_i(tgl_stb),
		.timer_overflow_i(tmr_ovf), .clock_port_wr_i(cp_wr), .clock_port_wdata_i(cp_wd), .shift_register_wr_i(sr_wr),
		.shift_register_wdata_i(sr_wd), .count_wr_i(cnt_wr), .count_wdata_i(cnt_wd), .shift_register_o(sr),
		.count_o(cnt), .start_clr_i(start_clr), .ovf_clr_i(ovf_clr), .stop_clr_i(1'b0), .start_detect_flag_o(st_f),
		.count_overflow_flag_o(ovf_f), .stop_flag_o(), .collision_o(), .count_wrap_o(wrap), .start_irq_o(s_irq),
		.idle_wake_o(idle_w), .powerdown_wake_o(pd_wake), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
		.rx_data_o(rx_data)
	);

	ussu_partner u_far (
		.go_i(p_go), .mode1_i(p_mode1), .tx_i(p_tx), .miso_i(so), .sck_o(p_sck), .mosi_o(p_mosi),
		.rx_o(p_rx), .busy_o(p_busy)
	);

	// ==========================================================
	// Helpers
	task chk(input [7:0] got, input [7:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task cyc(input integer n);
		repeat (n) @(posedge sys_clk);
	endtask

	task load(input [7:0] v, input [3:0] c);
		@(posedge sys_clk);
		sr_wr <= 1'b1;
		sr_wd <= v;
		cnt_wr <= 1'b1;
		cnt_wd <= c;
		ovf_clr <= 1'b1;
		@(posedge sys_clk);
		{sr_wr, cnt_wr, ovf_clr} <= 3'h0;
	endtask

	// Strobe kind: 0 soft clock, 1 timer, 2 clock toggle, 3 start clear, 4 clock port write
	task stb(input integer s);
		@(posedge sys_clk);
		{cp_wr, start_clr, tgl_stb, tmr_ovf, soft_stb} <= 5'h01 << s;
		@(posedge sys_clk);
		{cp_wr, start_clr, tgl_stb, tmr_ovf, soft_stb} <= 5'h00;
	endtask

	task pop(input [7:0] e);
		@(negedge sys_clk);
		chk(rx_valid, 1'b1);
		chk(rx_data, e);
		@(posedge sys_clk) rx_ready <= 1'b1;
		@(posedge sys_clk) rx_ready <= 1'b0;
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial begin
		#400000;
		error_cnt = error_cnt + 1;
		end_of_test;
	end

	// ==========================================================
	// Tests
	initial begin
		{irq_en, cp_wr, cp_wd, ext_sel, edge_sel, clk_dir, data_dir, soft_stb, tgl_stb, tmr_ovf, sr_wr, cnt_wr} = 12'h000;
		{start_clr, ovf_clr, rx_ready, loop, p_go, p_mode1, sr_wd, p_tx, cnt_wd} = 26'h000_0000;
		{rst_b, tb_scl, tb_sda, wm} = 5'h0D;
		cyc(10);
		rst_b <= 1'b1;
		cyc(30);
		chk(sr, 8'h00);
		chk(cnt, 4'h0);
		chk(ovf_f, 1'b0);
		$display("reset test done");

		load(8'hA5, 4'h0);
		stb(0);
		@(negedge sys_clk);
		chk(sr, 8'h4B);
		chk(cnt, 4'h1);
		@(posedge sys_clk);
		soft_stb <= 1'b1;
		sr_wr <= 1'b1;
		sr_wd <= 8'h3C;
		@(posedge sys_clk);
		{soft_stb, sr_wr} <= 2'h0;
		@(negedge sys_clk);
		chk(sr, 8'h3C);
		for (k = 0; k < 5; k = k + 1) begin
			m = 8'hC3 << k;
			edge_sel <= (k == 1);
			load(m, 4'hF);
			stb(k == 1);
			cyc(2);
			chk(cnt, 4'h0);
			chk(ovf_f, 1'b1);
			chk(idle_w, 1'b0);
			chk(sr, {m[6:0], 1'b1});
			exp_q.push_back({m[6:0], 1'b1});
		end
		while (exp_q.size() > 0)
			pop(exp_q.pop_front());
		@(negedge sys_clk);
		chk(rx_valid, 1'b0);
		$display("internal clock and buffer test done");

		@(posedge sys_clk);
		irq_en <= 1'b1;
		tb_scl <= 1'b0;
		data_dir <= 1'b1;
		cyc(6);
		ext_sel <= 1'b1;
		for (k = 0; k < 2; k = k + 1) begin
			edge_sel <= k[0];
			p_mode1 <= k[0];
			p_tx <= k ? 8'h96 : 8'h5A;
			load(k ? 8'h69 : 8'hC3, 4'h0);
			@(posedge sys_clk) p_go <= 1'b1;
			@(posedge sys_clk) p_go <= 1'b0;
			for (i = 0; i < 500 && p_busy; i = i + 1)
				@(posedge sys_clk);
			chk(p_busy, 1'b0);
			cyc(8);
			chk(p_rx, k ? 8'h69 : 8'hC3);
			chk(sr, p_tx);
			chk(cnt, 4'h0);
			chk(ovf_f, 1'b1);
			chk(idle_w, 1'b1);
			pop(p_tx);
		end
		$display("three-wire slave test done");

		edge_sel <= 1'b0;
		clk_dir <= 1'b1;
		loop <= 1'b1;
		tb_scl <= 1'b1;
		load(8'hA7, 4'h0);
		for (i = 0; i < 16; i = i + 1) begin
			cp_wd <= ~i[0];
			stb((i < 8) ? 2 : 4);
			cyc(6);
			if (i == 0 || i == 8)
				chk(scl_o, 1'b1);
		end
		chk(sr, 8'hA7);
		chk(cnt, 4'h0);
		chk(ovf_f, 1'b1);
		pop(8'hA7);
		$display("three-wire master test done");

		{clk_dir, loop, data_dir, ext_sel} <= 4'h0;
		wm <= 2'h2;
		cyc(20);
		tb_sda <= 1'b0; // Data falls while clock high
		@(negedge sys_clk);
		chk(pd_wake, 1'b1);
		cyc(4);
		chk(st_f, 1'b0);
		cyc(12);
		chk(st_f, 1'b1);
		chk(s_irq, 1'b1);
		tb_scl <= 1'b0;
		cyc(8);
		tb_scl <= 1'b1;
		cyc(8);
		chk(scl_oe, 1'b1);
		chk(scl_w, 1'b0);
		stb(3);
		cyc(3);
		chk(st_f, 1'b0);
		chk(scl_oe, 1'b0);
		chk(scl_w, 1'b1);
		$display("two-wire start test done");
		end_of_test;
	end
endmodule // tb_ussu_core
